// file: hw/logic_slice_block.sv
// four-slice programmable logic block with a wishbone configuration port
//
// Design decisions made here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ns
module logic_slice_block #(
   parameter bit RAM_CAPABLE = 1'b1
) (
   input  wire logic                            clk_i,
   input  wire logic                            rst_i,
   input  wire logic [7:0]                      wb_adr_i,
   input  wire logic [31:0]                     wb_dat_i,
   input  wire logic [3:0]                      wb_sel_i,
   input  wire logic                            wb_we_i,
   input  wire logic                            wb_cyc_i,
   input  wire logic                            wb_stb_i,
   output logic      [31:0]                     wb_dat_o,
   output logic                                 wb_ack_o,
   input  wire logic_slice_pkg::slice_in_t [3:0] slice_i,
   input  wire logic                            wide_func_in_a_i,
   input  wire logic                            wide_func_in_b_i,
   input  wire logic                            fast_carry_in_i,
   output logic_slice_pkg::slice_out_t [3:0]    slice_o,
   output logic                                 fast_carry_out_o
);

   //=======================================================================
   // helpers
   function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction : lane_merge

   // requests a slice cannot honour fall back to the nearest legal mode
   function automatic logic_slice_pkg::mode_t eff_mode(input int s,
                                                       input logic [1:0] m);
      logic_slice_pkg::mode_t r;
      r = logic_slice_pkg::mode_t'(m);
      if (r == logic_slice_pkg::MODE_RIPPLE && s == 3) begin
         r = logic_slice_pkg::MODE_LOGIC;
      end
      if (r == logic_slice_pkg::MODE_RAM &&
          !(RAM_CAPABLE && (s == 0 || s == 2))) begin
         r = logic_slice_pkg::MODE_ROM;
      end
      return r;
   endfunction : eff_mode

   // returns {carry_out, result[1:0]}
   function automatic logic [2:0] ripple_f(input logic [3:0] fn,
                                           input logic [1:0] a,
                                           input logic [1:0] b,
                                           input logic [1:0] q,
                                           input logic       cin,
                                           input logic       dir);
      logic [2:0] r;
      r = 3'h0;
      case (logic_slice_pkg::func_t'(fn))
         logic_slice_pkg::FN_ADD:
            r = {1'b0, a} + {1'b0, b} + {2'h0, cin};
         logic_slice_pkg::FN_SUB:
            r = {1'b0, a} + {1'b0, ~b} + {2'h0, cin};
         logic_slice_pkg::FN_ADDSUB:
            r = dir ? {1'b0, a} + {1'b0, b} + {2'h0, cin}
                    : {1'b0, a} + {1'b0, ~b} + {2'h0, cin};
         logic_slice_pkg::FN_UP:
            r = {1'b0, q} + {2'h0, cin};
         logic_slice_pkg::FN_DOWN:
            r = {1'b0, q} - {2'h0, cin};
         logic_slice_pkg::FN_UPDOWN:
            r = dir ? {1'b0, q} + {2'h0, cin}
                    : {1'b0, q} - {2'h0, cin};
         logic_slice_pkg::FN_GE: r = {2'h0, a >= b};
         logic_slice_pkg::FN_NE: r = {2'h0, a != b};
         logic_slice_pkg::FN_LE: r = {2'h0, a <= b};
         logic_slice_pkg::FN_MULT:
            r = {1'b0, a & {2{dir}}} + {1'b0, b} + {2'h0, cin};
         default: r = 3'h0;
      endcase
      return r;
   endfunction : ripple_f

   //=======================================================================
   // configuration state
   logic [15:0] lut_ff  [8];
   logic [11:0] mode_ff [4];
   logic        cfg_active_ff;
   logic [31:0] rd_data;
   logic        ack_ff;
   logic [31:0] dat_ff;
   logic        bus_acc;
   logic        is_lut;
   logic        is_mode;

   //=======================================================================
   // slice clock synchronisers: three stages, a change counts once the
   // second and third agree, so a glitch shorter than a cycle is dropped
   logic [3:0]  clk_s1_ff;
   logic [3:0]  clk_s2_ff;
   logic [3:0]  clk_s3_ff;
   logic [3:0]  clk_lvl_ff;
   logic [3:0]  rise_det;
   logic [3:0]  fall_det;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clk_s1_ff  <= 4'h0;
         clk_s2_ff  <= 4'h0;
         clk_s3_ff  <= 4'h0;
         clk_lvl_ff <= 4'h0;
      end else begin
         for (int s = 0; s < 4; s++) begin
            clk_s1_ff[s] <= slice_i[s].slice_clock;
            if (clk_s2_ff[s] == clk_s3_ff[s]) begin
               clk_lvl_ff[s] <= clk_s3_ff[s];
            end
         end
         clk_s2_ff <= clk_s1_ff;
         clk_s3_ff <= clk_s2_ff;
      end
   end

   always_comb begin
      for (int s = 0; s < 4; s++) begin
         rise_det[s] = (clk_s2_ff[s] == clk_s3_ff[s]) &&
                       clk_s3_ff[s] && !clk_lvl_ff[s];
         fall_det[s] = (clk_s2_ff[s] == clk_s3_ff[s]) &&
                       !clk_s3_ff[s] && clk_lvl_ff[s];
      end
   end

   //=======================================================================
   // slice datapath
   logic_slice_pkg::mode_t mode_e [4];
   logic [3:0] f_lo_c;
   logic [3:0] f_hi_c;
   logic [3:0] five_input_mux_out_c;
   logic [3:0] wide_mux_out_c;
   logic [3:0] cin_c;
   logic [3:0] cout_c;
   logic [1:0] d_c   [4];
   logic [1:0] q_ff  [3];
   logic [2:0] rip_c [4];
   logic [3:0] waddr;
   logic [3:0] wdata;
   logic       mem_write_enable;
   logic       mem_write_clock;

   // slice 1 supplies memory control to slices 0 and 2
   assign waddr            = slice_i[1].table_in_lo;
   assign mem_write_enable = slice_i[1].local_set_reset;
   assign mem_write_clock  = rise_det[1];
   assign wdata = {slice_i[2].multipurpose_in_hi,
                   slice_i[2].multipurpose_in_lo,
                   slice_i[0].multipurpose_in_hi,
                   slice_i[0].multipurpose_in_lo};

   always_comb begin
      cin_c[0] = fast_carry_in_i;
      for (int s = 0; s < 4; s++) begin
         mode_e[s] = eff_mode(s, mode_ff[s][logic_slice_pkg::MODE_LSB +: 2]);
         // memory read port is the same table lookup, no clock
         f_lo_c[s] = lut_ff[2*s][slice_i[s].table_in_lo];
         f_hi_c[s] = lut_ff[2*s+1][slice_i[s].table_in_hi];
         five_input_mux_out_c[s] = slice_i[s].multipurpose_in_lo ? f_hi_c[s]
                                                   : f_lo_c[s];
         if (s < 3) begin
            rip_c[s] = ripple_f(
               mode_ff[s][logic_slice_pkg::FUNC_LSB +: 4],
               slice_i[s].table_in_lo[1:0], slice_i[s].table_in_hi[1:0],
               q_ff[s], cin_c[s], slice_i[s].multipurpose_in_lo);
         end else begin
            rip_c[s] = 3'h0;
         end
         if (mode_e[s] != logic_slice_pkg::MODE_RIPPLE) begin
            rip_c[s] = {1'b0, f_hi_c[s], f_lo_c[s]};
         end
         cout_c[s] = rip_c[s][2];
         if (s < 3) begin
            cin_c[s+1] = cout_c[s];
         end
         d_c[s] = rip_c[s][1:0];
         if (mode_e[s] == logic_slice_pkg::MODE_RIPPLE &&
             logic_slice_pkg::func_t'(
                mode_ff[s][logic_slice_pkg::FUNC_LSB +: 4]) ==
             logic_slice_pkg::FN_UPDOWN &&
             slice_i[s].multipurpose_in_hi) begin
            d_c[s] = slice_i[s].table_in_lo[1:0];
         end
      end
      // wide functions: slices 1 and 3 build six inputs, slice 2 seven,
      // slice 0 eight from the neighbouring block's seven-input results
      wide_mux_out_c[1] = slice_i[1].multipurpose_in_hi ? five_input_mux_out_c[1]
                                                : five_input_mux_out_c[0];
      wide_mux_out_c[3] = slice_i[3].multipurpose_in_hi ? five_input_mux_out_c[3]
                                                : five_input_mux_out_c[2];
      wide_mux_out_c[2] = slice_i[2].multipurpose_in_hi ? wide_mux_out_c[3]
                                                : wide_mux_out_c[1];
      wide_mux_out_c[0] = slice_i[0].multipurpose_in_hi ? wide_func_in_b_i
                                                : wide_func_in_a_i;
   end

   //=======================================================================
   // storage elements of slices 0-2; slice 3 has none
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int s = 0; s < 3; s++) begin
            q_ff[s] <= 2'h0;
         end
      end else begin
         for (int s = 0; s < 3; s++) begin
            logic act;
            logic srv;
            act = 1'b0;
            srv = mode_ff[s][logic_slice_pkg::SRVAL_BIT];
            case (logic_slice_pkg::edge_t'(
                     mode_ff[s][logic_slice_pkg::EDGE_LSB +: 2]))
               logic_slice_pkg::EDGE_RISE:  act = rise_det[s];
               logic_slice_pkg::EDGE_FALL:  act = fall_det[s];
               logic_slice_pkg::EDGE_LATCH: act = clk_lvl_ff[s];
               default:                     act = rise_det[s];
            endcase
            if (slice_i[s].local_set_reset &&
                mode_ff[s][logic_slice_pkg::ASYNC_BIT]) begin
               q_ff[s] <= {2{srv}};
            end else if (act) begin
               if (slice_i[s].local_set_reset) begin
                  q_ff[s] <= {2{srv}};
               end else if (slice_i[s].clock_enable) begin
                  q_ff[s] <= d_c[s];
               end
            end
         end
      end
   end

   //=======================================================================
   // truth tables: bus writes only while configuring; memory writes from
   // the slice 1 clock edge, never during configuration
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < 8; i++) begin
            lut_ff[i] <= logic_slice_pkg::LUT_RST;
         end
      end else if (bus_acc && wb_we_i && is_lut && cfg_active_ff) begin
         lut_ff[wb_adr_i[4:2]] <= 16'(lane_merge(
            {16'h0000, lut_ff[wb_adr_i[4:2]]}, wb_dat_i, wb_sel_i));
      end else if (!cfg_active_ff && mem_write_enable &&
                   mem_write_clock) begin
         for (int s = 0; s < 3; s += 2) begin
            if (mode_e[s] == logic_slice_pkg::MODE_RAM) begin
               lut_ff[2*s][waddr]   <= wdata[s];
               lut_ff[2*s+1][waddr] <= wdata[s+1];
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int s = 0; s < 4; s++) begin
            mode_ff[s] <= logic_slice_pkg::MODE_RST;
         end
         cfg_active_ff <= logic_slice_pkg::CFG_RST;
      end else if (bus_acc && wb_we_i) begin
         if (is_mode) begin
            mode_ff[wb_adr_i[3:2]] <= 12'(lane_merge(
               {20'h00000, mode_ff[wb_adr_i[3:2]]}, wb_dat_i, wb_sel_i));
         end else if (wb_adr_i == logic_slice_pkg::OFS_CFG &&
                      wb_sel_i[0]) begin
            cfg_active_ff <= wb_dat_i[logic_slice_pkg::CFG_ACTIVE_BIT];
         end
      end
   end

   //=======================================================================
   // wishbone slave: one wait state, unmapped reads give zero
   assign bus_acc = wb_cyc_i && wb_stb_i && !ack_ff;
   assign is_lut  = wb_adr_i[7:5] == logic_slice_pkg::OFS_LUT_BASE[7:5];
   assign is_mode = wb_adr_i[7:4] == logic_slice_pkg::OFS_MODE_BASE[7:4];

   always_comb begin
      rd_data = 32'h0000_0000;
      if (is_lut) begin
         rd_data = {16'h0000, lut_ff[wb_adr_i[4:2]]};
      end else if (is_mode) begin
         rd_data = {20'h00000, mode_ff[wb_adr_i[3:2]]};
      end else if (wb_adr_i == logic_slice_pkg::OFS_STATUS) begin
         rd_data = {20'h00000, RAM_CAPABLE, cfg_active_ff, clk_lvl_ff,
                    q_ff[2], q_ff[1], q_ff[0]};
      end else if (wb_adr_i == logic_slice_pkg::OFS_CFG) begin
         rd_data = {31'h0000_0000, cfg_active_ff};
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
         dat_ff <= 32'h0000_0000;
      end else begin
         ack_ff <= bus_acc;
         if (bus_acc && !wb_we_i) begin
            dat_ff <= rd_data;
         end
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = dat_ff;

   //=======================================================================
   // registered slice outputs
   logic [3:0] f_lo_ff;
   logic [3:0] f_hi_ff;
   logic [3:0] five_input_mux_out_ff;
   logic [3:0] wide_mux_out_ff;
   logic       fco_ff;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         f_lo_ff <= 4'h0;
         f_hi_ff <= 4'h0;
         five_input_mux_out_ff <= 4'h0;
         wide_mux_out_ff <= 4'h0;
         fco_ff  <= 1'b0;
      end else begin
         for (int s = 0; s < 4; s++) begin
            f_lo_ff[s] <= rip_c[s][0];
            f_hi_ff[s] <= rip_c[s][1];
         end
         five_input_mux_out_ff <= five_input_mux_out_c;
         wide_mux_out_ff <= wide_mux_out_c;
         fco_ff  <= cout_c[2];
      end
   end

   always_comb begin
      for (int s = 0; s < 4; s++) begin
         slice_o[s].table_bypass_out_lo = f_lo_ff[s];
         slice_o[s].table_bypass_out_hi = f_hi_ff[s];
         slice_o[s].five_input_mux_out  = five_input_mux_out_ff[s];
         slice_o[s].wide_mux_out        = wide_mux_out_ff[s];
         slice_o[s].flop_out_lo         = (s < 3) ? q_ff[s % 3][0] : 1'b0;
         slice_o[s].flop_out_hi         = (s < 3) ? q_ff[s % 3][1] : 1'b0;
      end
   end
   assign fast_carry_out_o = fco_ff;

   //=======================================================================
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_s3_no_flop;
      slice_o[3].flop_out_lo == 1'b0 && slice_o[3].flop_out_hi == 1'b0;
   endproperty
   a_s3_no_flop: assert property (p_s3_no_flop)
      else $error("slice 3 shows a storage value");

   property p_async_sr;
      slice_i[0].local_set_reset &&
      mode_ff[0][logic_slice_pkg::ASYNC_BIT]
      |=> q_ff[0] == {2{$past(mode_ff[0][logic_slice_pkg::SRVAL_BIT])}};
   endproperty
   a_async_sr: assert property (p_async_sr)
      else $error("asynchronous set/reset not applied");

   property p_rise_capture;
      mode_ff[0][9:8] == 2'h0 && rise_det[0] &&
      !slice_i[0].local_set_reset && slice_i[0].clock_enable
      |=> q_ff[0] == $past(d_c[0]);
   endproperty
   a_rise_capture: assert property (p_rise_capture)
      else $error("rising edge capture missed");

   property p_fall_hold;
      mode_ff[0][9:8] == 2'h1 && !fall_det[0] &&
      !slice_i[0].local_set_reset |=> $stable(q_ff[0]);
   endproperty
   a_fall_hold: assert property (p_fall_hold)
      else $error("falling edge flop changed off its edge");

   property p_table_out;
      mode_e[1] == logic_slice_pkg::MODE_LOGIC
      |=> slice_o[1].table_bypass_out_lo == $past(f_lo_c[1]) &&
          slice_o[1].five_input_mux_out == $past(five_input_mux_out_c[1]);
   endproperty
   a_table_out: assert property (p_table_out)
      else $error("table output does not follow truth table");

   property p_ram_lo;
      mode_e[0] == logic_slice_pkg::MODE_RAM && !cfg_active_ff &&
      mem_write_enable && mem_write_clock && !(bus_acc && wb_we_i)
      |=> lut_ff[0][$past(waddr)] == $past(wdata[0]);
   endproperty
   a_ram_lo: assert property (p_ram_lo)
      else $error("slice 0 memory write lost");

   property p_ram_hi;
      mode_e[2] == logic_slice_pkg::MODE_RAM && !cfg_active_ff &&
      mem_write_enable && mem_write_clock && !(bus_acc && wb_we_i)
      |=> lut_ff[5][$past(waddr)] == $past(wdata[3]);
   endproperty
   a_ram_hi: assert property (p_ram_hi)
      else $error("slice 2 memory write lost");

   property p_s1_no_ram;
      !(bus_acc && wb_we_i) |=> $stable(lut_ff[2]) && $stable(lut_ff[3]);
   endproperty
   a_s1_no_ram: assert property (p_s1_no_ram)
      else $error("slice 1 table changed without a bus write");

   // slice 3 table: never memory, so only the bus could change it
   property p_rom_locked;
      bus_acc && wb_we_i && is_lut && !cfg_active_ff &&
      wb_adr_i[4:2] == 3'h6 |=> $stable(lut_ff[6]);
   endproperty
   a_rom_locked: assert property (p_rom_locked)
      else $error("table written outside configuration");

   property p_ack_once;
      bus_acc |=> wb_ack_o ##1 !wb_ack_o;
   endproperty
   a_ack_once: assert property (p_ack_once)
      else $error("bus acknowledge not a single pulse");

endmodule : logic_slice_block

// file: hw/logic_slice_pkg.sv
// constants, types and field layout for the four-slice logic block
//==========================================================================
// Contract
// - slices 0-2 two tables two flops; 3 two tables, no flops
// - memory only slices 0,2 of RAM block
// - set/reset selectable synchronous or asynchronous
// - storage rising, falling or level latch
// - slices 0-2 carry in and carry out
// - slice 3 has no carry connections
// - per-slice enable, set/reset, clock, table inputs
// - bypass and registered outputs per slice
// - slice 1 clock and set/reset control memory
// - write data high pair slice 2, low slice 0
// - write address from slice 1 table inputs
// - table is sixteen-entry programmed truth table
// - two tables muxed into five-input function
// - wider functions cascade through wide inputs
// - two-bit add, subtract, dynamic add/subtract
// - up, down, up/down counters, clear, preload
// - compare ge, ne, le; multiplier building block
// - carry chains; slice 2 drives block carry
// - 16x4 single-port memory over three slices
// - 16x2 pseudo dual-port, companion reads only
// - ROM contents loaded only while configuring
package logic_slice_pkg;

   //=======================================================================
   // register map
   localparam logic [7:0]  OFS_LUT_BASE  = 8'h00;
   localparam logic [7:0]  OFS_MODE_BASE = 8'h20;
   localparam logic [7:0]  OFS_STATUS    = 8'h30;
   localparam logic [7:0]  OFS_CFG       = 8'h34;

   //=======================================================================
   // slice mode register fields
   localparam int          MODE_LSB   = 0;
   localparam int          FUNC_LSB   = 4;
   localparam int          EDGE_LSB   = 8;
   localparam int          ASYNC_BIT  = 10;
   localparam int          SRVAL_BIT  = 11;
   localparam int          MODE_W     = 12;
   localparam int          CFG_ACTIVE_BIT = 0;

   //=======================================================================
   // reset values
   localparam logic [15:0] LUT_RST  = 16'h0000;
   localparam logic [11:0] MODE_RST = 12'h000;
   localparam logic        CFG_RST  = 1'h1;

   typedef enum logic [1:0] {
      MODE_LOGIC  = 2'h0,
      MODE_RIPPLE = 2'h1,
      MODE_RAM    = 2'h2,
      MODE_ROM    = 2'h3
   } mode_t;

   typedef enum logic [3:0] {
      FN_ADD    = 4'h0,
      FN_SUB    = 4'h1,
      FN_ADDSUB = 4'h2,
      FN_UP     = 4'h3,
      FN_DOWN   = 4'h4,
      FN_UPDOWN = 4'h5,
      FN_GE     = 4'h6,
      FN_NE     = 4'h7,
      FN_LE     = 4'h8,
      FN_MULT   = 4'h9
   } func_t;

   typedef enum logic [1:0] {
      EDGE_RISE  = 2'h0,
      EDGE_FALL  = 2'h1,
      EDGE_LATCH = 2'h2
   } edge_t;

   typedef struct packed {
      logic [3:0] table_in_lo;
      logic [3:0] table_in_hi;
      logic       multipurpose_in_lo;
      logic       multipurpose_in_hi;
      logic       clock_enable;
      logic       local_set_reset;
      logic       slice_clock;
   } slice_in_t;

   typedef struct packed {
      logic table_bypass_out_lo;
      logic table_bypass_out_hi;
      logic flop_out_lo;
      logic flop_out_hi;
      logic five_input_mux_out;
      logic wide_mux_out;
   } slice_out_t;

endpackage : logic_slice_pkg

// file: dv/neighbour_fabric.sv
// neighbour block model feeding the cascade and carry inputs
`timescale 1ns/1ns
module neighbour_fabric (
   input  wire logic       clk_i,
   input  wire logic [2:0] pick_i,
   output logic            wide_a_o = 1'b0,
   output logic            wide_b_o = 1'b0,
   output logic            carry_o = 1'b0
);
   // results leave a register, as a real neighbour's would
   always @(posedge clk_i) {carry_o, wide_b_o, wide_a_o} <= pick_i;
endmodule : neighbour_fabric

// file: dv/fpga_logic_slice_bench.sv
// randomised self-checking bench for the four-slice logic block
`timescale 1ns/1ns
module fpga_logic_slice_bench;
   typedef logic_slice_pkg::slice_in_t [3:0] sl_t;
   logic        clk, rst, we, cyc, stb, ack, co, wa, wb, ci;
   logic [7:0]  adr;
   logic [31:0] wd, rd;
   logic [3:0]  sel;
   logic [2:0]  pick;
   sl_t         si;
   logic_slice_pkg::slice_out_t [3:0] so;
   int          n_mismatch, check_count;

   logic_slice_block u_dut (.clk_i(clk), .rst_i(rst), .wb_adr_i(adr),
      .wb_dat_i(wd), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_dat_o(rd), .wb_ack_o(ack), .slice_i(si),
      .wide_func_in_a_i(wa), .wide_func_in_b_i(wb), .fast_carry_in_i(ci),
      .slice_o(so), .fast_carry_out_o(co));
   neighbour_fabric u_nb (.clk_i(clk), .pick_i(pick), .wide_a_o(wa),
      .wide_b_o(wb), .carry_o(ci));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   //==========================================================
   // helpers
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         $display("wrong value t=%0t got %h exp %h", $time, g, e);
         n_mismatch++;
      end
   endtask : chk

   task automatic bus(input logic [7:0] a, input logic [31:0] d,
                      input logic w, output logic [31:0] r);
      @(posedge clk);
      adr <= a;
      wd <= d;
      we <= w;
      cyc <= 1'b1;
      stb <= 1'b1;
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      r = rd;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : bus

   // outputs are registered behind the neighbour's own register
   task automatic drive(input sl_t s, input logic [2:0] p);
      @(posedge clk);
      si <= s;
      pick <= p;
      repeat (2) @(posedge clk);
      @(negedge clk);
   endtask : drive

   // slice clocks stay low: random toggles would break their spacing
   function automatic sl_t rnd();
      sl_t s;
      s = 52'({$urandom, $urandom});
      for (int i = 0; i < 4; i++) s[i].slice_clock = 1'b0;
      return s;
   endfunction : rnd

   function automatic logic [6:0] rip(input sl_t s, input logic c,
                                      input logic sub);
      logic [5:0] a, b;
      a = {s[2].table_in_lo[1:0], s[1].table_in_lo[1:0],
           s[0].table_in_lo[1:0]};
      b = {s[2].table_in_hi[1:0], s[1].table_in_hi[1:0],
           s[0].table_in_hi[1:0]};
      if (sub) b = ~b;
      return 7'(a) + 7'(b) + 7'(c);
   endfunction : rip

   task automatic final_report;
      if (n_mismatch == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : final_report

   //==========================================================
   // scenarios
   initial begin
      logic [31:0] r;
      logic [15:0] t [3];
      logic [3:0]  d, a;
      logic [2:0]  p;
      sl_t         s;
      n_mismatch = 0;
      check_count = 0;
      rst = 1'b1;
      {adr, wd, we, cyc, stb} = '0;
      sel = 4'hF;
      si = '0;
      pick = '0;
      void'($urandom(32'hE3B147B1));
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      bus(8'h24, 32'h0, 1'b0, r);
      chk(r, 32'h0);
      bus(8'h30, 32'h0, 1'b0, r);
      chk(r & 32'hC00, 32'hC00);
      bus(8'h3C, '1, 1'b1, r);
      bus(8'h3C, 32'h0, 1'b0, r);
      chk(r, 32'h0);
      for (int i = 0; i < 3; i++) begin
         t[i] = 16'($urandom);
         bus(8'(i < 2 ? 4 * i : 24), {16'h0, t[i]}, 1'b1, r);
      end
      for (int k = 0; k < 30; k++) begin
         s = rnd();
         p = 3'($urandom);
         drive(s, p);
         d = {2'b0, t[1][s[0].table_in_hi], t[0][s[0].table_in_lo]};
         chk(so[0].table_bypass_out_lo, d[0]);
         chk(so[0].table_bypass_out_hi, d[1]);
         chk(so[0].five_input_mux_out, d[s[0].multipurpose_in_lo]);
         chk(so[0].wide_mux_out, p[s[0].multipurpose_in_hi]);
         chk(so[3].table_bypass_out_lo, t[2][s[3].table_in_lo]);
         chk({so[3].flop_out_lo, so[3].flop_out_hi}, 0);
      end
      // one rising slice clock edge, then asynchronous set to one
      s = rnd();
      s[0].clock_enable = 1'b1;
      s[0].local_set_reset = 1'b0;
      drive(s, 3'h0);
      s[0].slice_clock = 1'b1;
      drive(s, 3'h0);
      drive(s, 3'h0);
      chk({so[0].flop_out_hi, so[0].flop_out_lo},
          {t[1][s[0].table_in_hi], t[0][s[0].table_in_lo]});
      bus(8'h20, 32'h0000_0C00, 1'b1, r);
      s[0].local_set_reset = 1'b1;
      drive(s, 3'h0);
      chk({so[0].flop_out_hi, so[0].flop_out_lo}, 32'h3);
      for (int f = 0; f < 2; f++) begin
         for (int j = 0; j < 3; j++)
            bus(8'(32 + 4 * j), 32'(16 * f + 1), 1'b1, r);
         for (int k = 0; k < 10; k++) begin
            // first iteration of each pass: zero operands with carry in, full borrow span when subtracting
            s = (k == 0) ? '0 : rnd();
            p = (k == 0) ? 3'h4 : 3'($urandom);
            drive(s, p);
            chk({co, so[2].table_bypass_out_hi, so[2].table_bypass_out_lo,
                 so[1].table_bypass_out_hi, so[1].table_bypass_out_lo,
                 so[0].table_bypass_out_hi, so[0].table_bypass_out_lo},
                rip(s, p[2], f == 1));
         end
      end
      // compare: slice 0 ge, slice 1 ne, slice 2 le; carry in ignored
      for (int j = 0; j < 3; j++)
         bus(8'(32 + 4 * j), 32'(16 * (6 + j) + 1), 1'b1, r);
      for (int k = 0; k < 8; k++) begin
         s = rnd();
         drive(s, 3'($urandom));
         chk({co, so[2].table_bypass_out_lo, so[1].table_bypass_out_lo,
              so[0].table_bypass_out_lo},
             {1'b0, s[2].table_in_lo[1:0] <= s[2].table_in_hi[1:0],
              s[1].table_in_lo[1:0] != s[1].table_in_hi[1:0],
              s[0].table_in_lo[1:0] >= s[0].table_in_hi[1:0]});
      end
      bus(8'h34, 32'h0, 1'b1, r);
      bus(8'h18, {16'h0, ~t[2]}, 1'b1, r);
      for (int j = 0; j < 3; j++)
         bus(8'(32 + 4 * j), 32'(j == 1 ? 0 : 2), 1'b1, r);
      for (int k = 0; k < 6; k++) begin
         d = 4'($urandom);
         a = 4'(k * 3);
         s = '0;
         s[1].table_in_lo = a;
         s[1].local_set_reset = 1'b1;
         {s[2].multipurpose_in_hi, s[2].multipurpose_in_lo,
          s[0].multipurpose_in_hi, s[0].multipurpose_in_lo} = d;
         drive(s, 3'h0);
         s[1].slice_clock = 1'b1;
         drive(s, 3'h0);
         drive(s, 3'h0);
         s = '0;
         s[0].table_in_lo = a;
         s[0].table_in_hi = a;
         s[2].table_in_lo = a;
         s[2].table_in_hi = a;
         s[3].table_in_lo = 4'($urandom);
         drive(s, 3'h0);
         chk({so[2].table_bypass_out_hi, so[2].table_bypass_out_lo,
              so[0].table_bypass_out_hi, so[0].table_bypass_out_lo},
             d);
         chk(so[3].table_bypass_out_lo, t[2][s[3].table_in_lo]);
      end
      final_report();
   end

   initial begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      final_report();
   end
endmodule : fpga_logic_slice_bench
